// ---- src/odsl_loader.sv ----
/*
 * Serial loader for an eight-channel 12-bit converter: shift register on the
 * link clock, address check, input latches, load and clear of the converter
 * latches on the system clock. Assumes i_clk at 20 MHz and pins that are
 * asynchronous to it; the link clock is the controller's shift clock.
 */
`timescale 1ns/1ps
module odsl_loader (
   input  wire logic        i_clk,
   input  wire logic        i_reset_n,
   input  wire logic        i_shift_clock,
   input  wire logic        i_frame_sync_n,
   input  wire logic        i_serial_data_in,
   input  wire logic        i_device_address_pin,
   input  wire logic        i_load_all_channels_n,
   input  wire logic        i_zero_outputs_n,
   output logic             o_chain_data_out,
   output logic [95:0]      o_converter_codes,
   output logic [95:0]      o_input_codes,
   output logic             o_word_accepted,
   output logic             o_word_ignored,
   output logic [7:0]       o_accepted_count,
   output logic [7:0]       o_ignored_count,
   output logic             o_frame_active
);

   // ----------------------------------------------------------------------
   // Declarations
   // ----------------------------------------------------------------------
   logic        link_word_done;
   logic [15:0] link_word;

   logic        done_meta_q;
   logic        done_sync_q;
   logic        done_prev_q;
   logic        addr_meta_q;
   logic        addr_sync_q;
   logic        load_meta_q;
   logic        load_sync_q;
   logic        zero_meta_q;
   logic        zero_sync_q;
   logic        frame_meta_q;
   logic        frame_sync_q;

   logic        new_word;
   logic [15:0] word_q;
   logic [15:0] word_d;

   odsl_pkg::odsl_state_e state_q;
   odsl_pkg::odsl_state_e state_d;

   logic        addr_match;
   logic        wr_en;
   logic [2:0]  wr_sel;
   logic [11:0] wr_data;
   logic [95:0] latches;
   logic        drop_now;

   logic        zero_active;
   logic        load_active;
   logic [95:0] codes_q;
   logic [95:0] codes_d;

   logic        accept_q;
   logic        ignore_q;
   logic [7:0]  acc_cnt_q;
   logic [7:0]  acc_cnt_d;
   logic [7:0]  ign_cnt_q;
   logic [7:0]  ign_cnt_d;

   // ----------------------------------------------------------------------
   // Helpers
   // ----------------------------------------------------------------------
   // Status counters stick at all ones rather than wrapping
   function automatic logic [7:0] sat_inc(input logic [7:0] value);
      sat_inc = (value == 8'hFF) ? value : value + odsl_pkg::STAT_ONE;
   endfunction

   // ----------------------------------------------------------------------
   // Link domain
   // ----------------------------------------------------------------------
   // Shift register and chain output on the shift clock
   odsl_link_shifter u_link (
      .i_shift_clock    (i_shift_clock),
      .i_frame_sync_n   (i_frame_sync_n),
      .i_serial_data_in (i_serial_data_in),
      .o_chain_data_out (o_chain_data_out),
      .o_word_done      (link_word_done),
      .o_word           (link_word)
   );

   // ----------------------------------------------------------------------
   // Synchronisers
   // ----------------------------------------------------------------------
   // Word-done level from the link domain, plus an edge stage
   always_ff @(posedge i_clk) begin
      if (!i_reset_n) begin
         done_meta_q <= 1'b0;
         done_sync_q <= 1'b0;
         done_prev_q <= 1'b0;
      end else begin
         done_meta_q <= link_word_done;
         done_sync_q <= done_meta_q;
         done_prev_q <= done_sync_q;
      end
   end

   // Address pin
   always_ff @(posedge i_clk) begin
      if (!i_reset_n) begin
         addr_meta_q <= 1'b0;
         addr_sync_q <= 1'b0;
      end else begin
         addr_meta_q <= i_device_address_pin;
         addr_sync_q <= addr_meta_q;
      end
   end

   // Load and clear pins, idle high
   always_ff @(posedge i_clk) begin
      if (!i_reset_n) begin
         load_meta_q <= 1'b1;
         load_sync_q <= 1'b1;
         zero_meta_q <= 1'b1;
         zero_sync_q <= 1'b1;
      end else begin
         load_meta_q <= i_load_all_channels_n;
         load_sync_q <= load_meta_q;
         zero_meta_q <= i_zero_outputs_n;
         zero_sync_q <= zero_meta_q;
      end
   end

   // Frame sync, for status only
   always_ff @(posedge i_clk) begin
      if (!i_reset_n) begin
         frame_meta_q <= 1'b1;
         frame_sync_q <= 1'b1;
      end else begin
         frame_meta_q <= i_frame_sync_n;
         frame_sync_q <= frame_meta_q;
      end
   end

   // ----------------------------------------------------------------------
   // Word hand-off
   // ----------------------------------------------------------------------
   // A full word is signalled by the rise of the done level
   assign new_word = done_sync_q & ~done_prev_q;

   // Held word is stable for sixteen link periods after done rises
   assign word_d = new_word ? link_word : word_q;

   always_ff @(posedge i_clk) begin
      if (!i_reset_n) begin
         word_q <= 16'h0000;
      end else begin
         word_q <= word_d;
      end
   end

   // ----------------------------------------------------------------------
   // Word decode
   // ----------------------------------------------------------------------
   // Address compare and field selection
   assign addr_match = (odsl_pkg::word_addr(word_q) == addr_sync_q);
   assign wr_sel     = odsl_pkg::word_sel(word_q);
   assign wr_data    = odsl_pkg::word_data(word_q);
   assign wr_en      = (state_q == odsl_pkg::ST_WRITE);
   assign drop_now   = (state_q == odsl_pkg::ST_DROP);

   // ----------------------------------------------------------------------
   // Word handling state machine
   // ----------------------------------------------------------------------
   // Idle, check address, then write or drop
   always_comb begin
      state_d = state_q;
      case (state_q)
         odsl_pkg::ST_IDLE: begin
            if (new_word) begin
               state_d = odsl_pkg::ST_CHECK;
            end
         end
         odsl_pkg::ST_CHECK: begin
            if (addr_match) begin
               state_d = odsl_pkg::ST_WRITE;
            end else begin
               state_d = odsl_pkg::ST_DROP;
            end
         end
         odsl_pkg::ST_WRITE: begin
            state_d = odsl_pkg::ST_IDLE;
         end
         odsl_pkg::ST_DROP: begin
            state_d = odsl_pkg::ST_IDLE;
         end
         default: begin
            state_d = odsl_pkg::ST_IDLE;
         end
      endcase
   end

   always_ff @(posedge i_clk) begin
      if (!i_reset_n) begin
         state_q <= odsl_pkg::ST_IDLE;
      end else begin
         state_q <= state_d;
      end
   end

   // ----------------------------------------------------------------------
   // Input latches
   // ----------------------------------------------------------------------
   // Written only by accepted words, never by clear
   odsl_input_latches u_latches (
      .i_clk     (i_clk),
      .i_reset_n (i_reset_n),
      .i_wr_en   (wr_en),
      .i_wr_sel  (wr_sel),
      .i_wr_data (wr_data),
      .o_latches (latches)
   );

   // ----------------------------------------------------------------------
   // Converter latches
   // ----------------------------------------------------------------------
   // Clear over load, load copies all eight channels
   assign zero_active = ~zero_sync_q;
   assign load_active = ~load_sync_q;
   assign codes_d     = zero_active ? odsl_pkg::CODES_RESET
                      : load_active ? latches
                      : codes_q;

   always_ff @(posedge i_clk) begin
      if (!i_reset_n) begin
         codes_q <= odsl_pkg::CODES_RESET;
      end else begin
         codes_q <= codes_d;
      end
   end

   // ----------------------------------------------------------------------
   // Status
   // ----------------------------------------------------------------------
   // Saturating counters of accepted and ignored words
   assign acc_cnt_d = wr_en ? sat_inc(acc_cnt_q) : acc_cnt_q;
   assign ign_cnt_d = drop_now ? sat_inc(ign_cnt_q) : ign_cnt_q;

   // Accepted-word counter
   always_ff @(posedge i_clk) begin
      if (!i_reset_n) begin
         acc_cnt_q <= odsl_pkg::STAT_RESET;
      end else begin
         acc_cnt_q <= acc_cnt_d;
      end
   end

   // Ignored-word counter
   always_ff @(posedge i_clk) begin
      if (!i_reset_n) begin
         ign_cnt_q <= odsl_pkg::STAT_RESET;
      end else begin
         ign_cnt_q <= ign_cnt_d;
      end
   end

   // One-cycle outcome pulses, registered
   always_ff @(posedge i_clk) begin
      if (!i_reset_n) begin
         accept_q <= 1'b0;
         ignore_q <= 1'b0;
      end else begin
         accept_q <= wr_en;
         ignore_q <= drop_now;
      end
   end

   // ----------------------------------------------------------------------
   // Outputs
   // ----------------------------------------------------------------------
   assign o_converter_codes = codes_q;
   assign o_input_codes     = latches;
   assign o_word_accepted   = accept_q;
   assign o_word_ignored    = ignore_q;
   assign o_accepted_count  = acc_cnt_q;
   assign o_ignored_count   = ign_cnt_q;
   assign o_frame_active    = ~frame_sync_q;

endmodule

// ---- src/odsl_pkg.sv ----
/*
 * Constants, state encoding and word-field helpers for the octal converter
 * serial loader. Assumes a 16-bit serial word, MSB first, eight channels.
 */
package odsl_pkg;

   // ----------------------------------------------------------------------
   // Word layout
   // ----------------------------------------------------------------------
   localparam int unsigned WORD_BITS    = 16;
   localparam int unsigned COUNT_WIDTH  = 5;
   localparam int unsigned DATA_WIDTH   = 12;
   localparam int unsigned DATA_MSB     = 15;
   localparam int unsigned DATA_LSB     = 4;
   localparam int unsigned ADDR_BIT     = 3;
   localparam int unsigned SEL_WIDTH    = 3;
   localparam int unsigned SEL_MSB      = 2;
   localparam int unsigned NUM_CHANNELS = 8;
   localparam int unsigned CODES_WIDTH  = 96;
   localparam int unsigned STAT_WIDTH   = 8;

   // ----------------------------------------------------------------------
   // Counts and reset values
   // ----------------------------------------------------------------------
   localparam logic [4:0]  FULL_COUNT   = 5'h10;
   localparam logic [4:0]  COUNT_RESET  = 5'h00;
   localparam logic [11:0] CODE_RESET   = 12'h000;
   localparam logic [95:0] CODES_RESET  = 96'h0;
   localparam logic [7:0]  STAT_RESET   = 8'h00;
   localparam logic [7:0]  STAT_ONE     = 8'h01;

   // ----------------------------------------------------------------------
   // Word handling states, Gray along idle-check-write
   // ----------------------------------------------------------------------
   typedef enum logic [1:0] {
      ST_IDLE  = 2'h0,
      ST_CHECK = 2'h1,
      ST_WRITE = 2'h3,
      ST_DROP  = 2'h2
   } odsl_state_e;

   // ----------------------------------------------------------------------
   // Field extraction
   // ----------------------------------------------------------------------
   function automatic logic [11:0] word_data(input logic [15:0] word);
      word_data = word[DATA_MSB:DATA_LSB];
   endfunction

   function automatic logic [2:0] word_sel(input logic [15:0] word);
      word_sel = word[SEL_MSB:0];
   endfunction

   function automatic logic word_addr(input logic [15:0] word);
      word_addr = word[ADDR_BIT];
   endfunction

endpackage

// ---- src/odsl_link_shifter.sv ----
/*
 * Link-side input shift register, clocked by the controller's shift clock.
 * Assumes frame sync and data change away from the falling shift-clock edge
 * and that the shift clock may stop while frame sync is high.
 */
`timescale 1ns/1ps
module odsl_link_shifter (
   input  wire logic        i_shift_clock,
   input  wire logic        i_frame_sync_n,
   input  wire logic        i_serial_data_in,
   output logic             o_chain_data_out,
   output logic             o_word_done,
   output logic [15:0]      o_word
);

   logic [4:0]  count_q;
   logic [15:0] shift_q;
   logic [15:0] word_q;
   logic        chain_q;
   logic        shifting;

   // ----------------------------------------------------------------------
   // Capture
   // ----------------------------------------------------------------------
   assign shifting = (count_q != odsl_pkg::FULL_COUNT);

   // Count restarts whenever frame sync is high
   always_ff @(negedge i_shift_clock or posedge i_frame_sync_n) begin
      if (i_frame_sync_n) begin
         count_q <= odsl_pkg::COUNT_RESET;
      end else if (shifting) begin
         count_q <= count_q + 5'h01;
      end
   end

   // Shift in on falling edges while framed
   always_ff @(negedge i_shift_clock) begin
      if (!i_frame_sync_n && shifting) begin
         shift_q <= {shift_q[14:0], i_serial_data_in};
      end
   end

   // Hold the completed word for the system side
   always_ff @(negedge i_shift_clock) begin
      if (!i_frame_sync_n && count_q == 5'h0F) begin
         word_q <= {shift_q[14:0], i_serial_data_in};
      end
   end

   // ----------------------------------------------------------------------
   // Chain output
   // ----------------------------------------------------------------------
   // Rising-edge output stage, held between frames so the next device gets bit 15 first
   always_ff @(posedge i_shift_clock) begin
      if (!i_frame_sync_n) begin
         chain_q <= shift_q[15];
      end
   end

   assign o_chain_data_out = chain_q;
   assign o_word_done      = ~shifting;
   assign o_word           = word_q;

endmodule

// ---- src/odsl_input_latches.sv ----
/*
 * Eight 12-bit input latches with one write port; all words are presented
 * at once from their storage registers. Assumes single-cycle write strobes.
 */
`timescale 1ns/1ps
module odsl_input_latches (
   input  wire logic        i_clk,
   input  wire logic        i_reset_n,
   input  wire logic        i_wr_en,
   input  wire logic [2:0]  i_wr_sel,
   input  wire logic [11:0] i_wr_data,
   output logic [95:0]      o_latches
);

   logic [11:0] mem_q [8];

   // ----------------------------------------------------------------------
   // Storage
   // ----------------------------------------------------------------------
   // Write the selected latch only
   always_ff @(posedge i_clk) begin
      if (!i_reset_n) begin
         for (int i = 0; i < 8; i++) begin
            mem_q[i] <= odsl_pkg::CODE_RESET;
         end
      end else if (i_wr_en) begin
         mem_q[i_wr_sel] <= i_wr_data;
      end
   end

   // Flatten, channel A in the low bits
   always_comb begin
      for (int i = 0; i < 8; i++) begin
         o_latches[i*12 +: 12] = mem_q[i];
      end
   end

endmodule

// ---- tb/odsl_loader_assertions.sv ----
/* Checker for the loader pins and status outputs.
   Assumes the i_clk domain and the bind below. */
`timescale 1ns/1ps
module odsl_loader_assertions (
   input  wire logic        i_clk,
   input  wire logic        i_reset_n,
   input  wire logic        i_frame_sync_n,
   input  wire logic        i_load_all_channels_n,
   input  wire logic        i_zero_outputs_n,
   input  wire logic [95:0] o_converter_codes,
   input  wire logic [95:0] o_input_codes,
   input  wire logic        o_word_accepted,
   input  wire logic        o_word_ignored,
   input  wire logic [7:0]  o_accepted_count,
   input  wire logic [7:0]  o_ignored_count,
   input  wire logic        o_frame_active
);
   // ---------------------------------------------------------------
   // Properties on the system clock
   // ---------------------------------------------------------------
   default clocking cb @(posedge i_clk); endclocking
   default disable iff (!i_reset_n);

   a_pulse_single: assert property ((o_word_accepted || o_word_ignored) |=>
      !o_word_accepted && !o_word_ignored) else $error("status pulse too long");
   a_accept_step: assert property (o_word_accepted |-> o_accepted_count ==
      $past(o_accepted_count) + 8'h01 || $past(o_accepted_count) == 8'hFF) else $error("accept count");
   a_ignore_step: assert property (o_word_ignored |-> o_ignored_count ==
      $past(o_ignored_count) + 8'h01 || $past(o_ignored_count) == 8'hFF) else $error("ignore count");
   a_count_cause: assert property ($changed(o_accepted_count) |-> o_word_accepted)
      else $error("accept count moved alone");
   a_write_pulse: assert property ($changed(o_input_codes) |-> o_word_accepted)
      else $error("latch write without accept");
   a_ignore_nowrite: assert property (o_word_ignored |->
      o_input_codes == $past(o_input_codes, 2)) else $error("ignored word written");
   a_clear_zero: assert property (!i_zero_outputs_n [*3] |=>
      o_converter_codes == 96'h0) else $error("clear not zero");
   a_load_track: assert property ((!i_load_all_channels_n && i_zero_outputs_n) [*4] |=>
      o_converter_codes == $past(o_input_codes)) else $error("load not tracking");
   a_load_hold: assert property ((i_load_all_channels_n && i_zero_outputs_n) [*4] |=>
      $stable(o_converter_codes)) else $error("converter moved");
   a_frame_flag: assert property (!i_frame_sync_n [*3] |=> o_frame_active)
      else $error("frame flag low");
endmodule

bind odsl_loader odsl_loader_assertions odsl_loader_assertions_i (
   .i_clk(i_clk), .i_reset_n(i_reset_n), .i_frame_sync_n(i_frame_sync_n),
   .i_load_all_channels_n(i_load_all_channels_n), .i_zero_outputs_n(i_zero_outputs_n),
   .o_converter_codes(o_converter_codes), .o_input_codes(o_input_codes),
   .o_word_accepted(o_word_accepted), .o_word_ignored(o_word_ignored),
   .o_accepted_count(o_accepted_count), .o_ignored_count(o_ignored_count),
   .o_frame_active(o_frame_active));

// ---- tb/odsl_ctrl_model.sv ----
/* Serial port model of the controller feeding the loader.
   Assumes the bench calls send_word; 80 ns link period. */
`timescale 1ns/1ps
module odsl_ctrl_model (
   input  wire logic        i_chain_data_out,
   output logic             o_shift_clock,
   output logic             o_frame_sync_n,
   output logic             o_serial_data_in,
   output logic [15:0]      o_chain_word
);
   // ---------------------------------------------------------------
   // Idle levels and frame sender
   // ---------------------------------------------------------------
   // Clock stands high between frames
   initial begin
      o_shift_clock    = 1'b1;
      o_frame_sync_n   = 1'b0;
      o_serial_data_in = 1'b0;
      o_chain_word     = 16'h0000;
      #1 o_frame_sync_n = 1'b1;  // One clean rise clears the link bit count
   end

   // MSB first, data valid at each falling edge
   task automatic send_word(input logic [15:0] word, input int nbits);
      logic [17:0] bits;
      bits = {word, ~word[1:0]};
      #13 o_frame_sync_n = 1'b0;
      for (int k = 0; k < nbits; k++) begin
         o_serial_data_in = bits[17 - k];
         #20 if (k < 16) o_chain_word = {o_chain_word[14:0], i_chain_data_out};  // Taken as a chained device would
         o_shift_clock = 1'b0;
         #40 o_shift_clock = 1'b1;
         #20;
      end
      o_frame_sync_n = 1'b1;
      o_serial_data_in = ~o_serial_data_in; // Released line shows no stale value
   endtask
endmodule

// ---- tb/odsl_loader_tb.sv ----
/* Self-checking bench for the serial loader.
   Assumes the controller model and the bound checker. */
`timescale 1ns/1ps
module odsl_loader_tb;
   logic        clk;
   logic        rst_n = 1'b0;
   logic        addr_pin = 1'b0;
   logic        load_n = 1'b1;
   logic        zero_n = 1'b1;
   wire         sck, fs_n, sdi, sdo;
   wire  [15:0] chain_word;
   logic [95:0] conv, inp, exp_in, exp_cv;
   logic [7:0]  acc_cnt, ign_cnt;
   logic [15:0] prev_word;
   int          miscompares = 0;
   int          tests_run = 0;
   int          cycles = 0;
   int          nfr = 0;

   odsl_ctrl_model odsl_ctrl_model_i (.i_chain_data_out(sdo), .o_shift_clock(sck),
      .o_frame_sync_n(fs_n), .o_serial_data_in(sdi), .o_chain_word(chain_word));
   odsl_loader odsl_loader_i (.i_clk(clk), .i_reset_n(rst_n), .i_shift_clock(sck),
      .i_frame_sync_n(fs_n), .i_serial_data_in(sdi), .i_device_address_pin(addr_pin),
      .i_load_all_channels_n(load_n), .i_zero_outputs_n(zero_n), .o_chain_data_out(sdo),
      .o_converter_codes(conv), .o_input_codes(inp), .o_word_accepted(), .o_word_ignored(),
      .o_accepted_count(acc_cnt), .o_ignored_count(ign_cnt), .o_frame_active());

   // ---------------------------------------------------------------
   // Clock, timeout and helpers
   // ---------------------------------------------------------------
   // System clock, 50 ns
   initial begin
      clk = 1'b0;
      forever #25 clk = ~clk;
   end

   // Hang guard
   always @(posedge clk) begin
      cycles++;
      if (cycles == 4000) begin
         miscompares++;
         give_verdict();
      end
   end

   task automatic check(input logic [95:0] seen, input logic [95:0] want, input string what);
      tests_run++;
      if (seen !== want) begin
         miscompares++;
         $display("wrong value at %0t: %s", $time, what);
      end
   endtask

   task automatic give_verdict();
      $display("checks %0d, mismatches %0d", tests_run, miscompares);
      if (miscompares == 0 && tests_run > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask

   // One frame, then wait for its status count
   task automatic frame(input logic [15:0] word, input int nbits, input logic take);
      logic [7:0] a0;
      logic [7:0] i0;
      a0 = acc_cnt;
      i0 = ign_cnt;
      odsl_ctrl_model_i.send_word(word, nbits);
      if (nfr > 0) check(chain_word, prev_word, "chain");
      for (int n = 0; n < 20; n++) if (acc_cnt == a0 && ign_cnt == i0) @(negedge clk);
      @(negedge clk);
      if (take) exp_in[word[2:0] * 12 +: 12] = word[15:4];
      check(take ? acc_cnt : ign_cnt, (take ? a0 : i0) + 8'h01, "count");
      check(inp, exp_in, "input codes");
      check(conv, exp_cv, "converter");
      prev_word = word;
      nfr++;
   endtask

   task automatic settle(input logic ld, input logic zr);
      load_n = ld;
      zero_n = zr;
      repeat (4) @(negedge clk);
   endtask

   // ---------------------------------------------------------------
   // Test sequence
   // ---------------------------------------------------------------
   // Main sequence
   initial begin
      exp_in = 96'h0;
      exp_cv = 96'h0;
      repeat (16) @(negedge clk);
      rst_n = 1'b1;
      @(negedge clk);
      check(conv | inp, 96'h0, "reset codes");
      $display("test reset done");
      for (int ch = 0; ch < 8; ch++) frame({12'hA50 + 12'(ch), 1'b0, 3'(ch)}, 16, 1'b1);
      frame({12'hFFF, 1'b1, 3'h2}, 16, 1'b0);
      addr_pin = 1'b1;
      repeat (4) @(negedge clk);
      frame({12'h123, 1'b1, 3'h7}, 16, 1'b1);
      frame({12'h456, 1'b0, 3'h7}, 16, 1'b0);
      frame({12'hFFF, 1'b1, 3'h0}, 18, 1'b1);
      frame({12'h001, 1'b1, 3'h1}, 16, 1'b1);
      $display("test serial done");
      settle(1'b0, 1'b1);
      exp_cv = exp_in;
      check(conv, exp_cv, "load");
      settle(1'b1, 1'b1);
      frame({12'h000, 1'b1, 3'h3}, 16, 1'b1);
      settle(1'b1, 1'b0);
      exp_cv = 96'h0;
      check(conv, exp_cv, "clear");
      check(inp, exp_in, "kept");
      settle(1'b0, 1'b0);
      check(conv, exp_cv, "clear wins");
      settle(1'b0, 1'b1);
      exp_cv = exp_in;
      check(conv, exp_cv, "restore");
      settle(1'b1, 1'b1);
      $display("test load clear done");
      rst_n = 1'b0;
      repeat (4) @(negedge clk);
      rst_n = 1'b1;
      exp_in = 96'h0;
      exp_cv = 96'h0;
      @(negedge clk);
      check(inp | acc_cnt, 96'h0, "second reset");
      frame({12'h7E1, 1'b1, 3'h5}, 16, 1'b1);
      $display("test second reset done");
      give_verdict();
   end
endmodule
